// ==== flash_seq_pkg.sv ====
`default_nettype none
package flash_seq_pkg;
  // ==========================================================
  // Clock and command codes
  localparam int unsigned CLK_MHZ          = 125;
  localparam logic [7:0]  OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0]  OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0]  OP_SMALL_ERASE   = 8'h20;
  localparam logic [7:0]  OP_BLOCK_ERASE   = 8'hd8;
  localparam logic [7:0]  OP_FULL_ERASE    = 8'hc7;
  localparam logic [7:0]  OP_SUSPEND       = 8'h75;
  localparam logic [7:0]  OP_RESUME        = 8'h7a;

  // ==========================================================
  // Framing
  localparam logic [1:0]  PROTO_EXT        = 2'h0;
  localparam logic [1:0]  PROTO_DUAL       = 2'h1;
  localparam logic [1:0]  PROTO_QUAD       = 2'h2;
  localparam logic [5:0]  OPCODE_BITS      = 6'h08;
  localparam logic [5:0]  ERASE_CMD_BITS   = 6'h20;
  localparam logic [5:0]  BIT_CNT_MAX      = 6'h3f;
  localparam int unsigned ADDR_BITS        = 24;
  localparam int unsigned SECTOR_LSB       = 16;
  localparam int unsigned SECTOR_MSB       = 21;
  localparam int unsigned NUM_SECTORS      = 64;
  localparam logic [3:0]  HOST_CS_HIGH_CYC = 4'h8;

  // ==========================================================
  // Flag status bit positions
  localparam int unsigned FLAG_PROT_BIT    = 1;
  localparam int unsigned FLAG_ERASE_BIT   = 5;
  localparam int unsigned FLAG_SUSP_BIT    = 6;
  localparam int unsigned FLAG_READY_BIT   = 7;

  // ==========================================================
  // Erase kinds and durations
  localparam logic [1:0]  KIND_NONE        = 2'h0;
  localparam logic [1:0]  KIND_SMALL       = 2'h1;
  localparam logic [1:0]  KIND_BLOCK       = 2'h2;
  localparam logic [1:0]  KIND_FULL        = 2'h3;
  localparam int unsigned SMALL_BLOCK_ERASE_TIME_US = 250;
  localparam int unsigned BLOCK_ERASE_TIME_US       = 700000;
  localparam int unsigned FULL_ARRAY_ERASE_TIME_US  = 10000000;
  localparam int unsigned SMALL_BLOCK_ERASE_CYC = SMALL_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned BLOCK_ERASE_CYC       = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned FULL_ARRAY_ERASE_CYC  = FULL_ARRAY_ERASE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_SUSP  = 3'b100
  } erase_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW  = 4'b0010,
    H_HIGH = 4'b0100,
    H_GAP  = 4'b1000
  } host_state_t;

  // Bits moved per serial clock for a protocol
  function automatic logic [2:0] lanes_of(input logic [1:0] mode);
    lanes_of = (mode == PROTO_QUAD) ? 3'h4 : (mode == PROTO_DUAL) ? 3'h2 : 3'h1;
  endfunction : lanes_of
endpackage : flash_seq_pkg
`default_nettype wire

// ==== spi_link_if.sv ====
`default_nettype none
interface spi_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] dq;
  modport host   (output cs_n, output sclk, output dq);
  modport device (input cs_n, input sclk, input dq);
endinterface : spi_link_if
`default_nettype wire

// ==== flash_cmd_host.sv ====
`default_nettype none
module flash_cmd_host (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  spi_link_if.host         link,
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_opcode_in,
  input  wire logic [23:0] cmd_addr_in,
  input  wire logic        cmd_has_addr_in,
  input  wire logic [1:0]  proto_mode_in,
  output logic             cmd_ready_out,
  output logic             cmd_done_out
);
  flash_seq_pkg::host_state_t state_ff;
  logic        cs_n_ff;
  logic        sclk_ff;
  logic [3:0]  dq_ff;
  logic [31:0] sh_ff;
  logic [5:0]  left_ff;
  logic [1:0]  mode_ff;
  logic [3:0]  gap_ff;
  logic        ready_ff;
  logic        done_ff;

  // Top lanes of a word, MSB first, lane 0 alone in extended mode
  function automatic logic [3:0] out_lanes(input logic [31:0] w, input logic [1:0] m);
    if (m == flash_seq_pkg::PROTO_QUAD) begin
      out_lanes = w[31:28];
    end else if (m == flash_seq_pkg::PROTO_DUAL) begin
      out_lanes = {2'h0, w[31:30]};
    end else begin
      out_lanes = {3'h0, w[31]};
    end
  endfunction : out_lanes

  assign link.cs_n    = cs_n_ff;
  assign link.sclk    = sclk_ff;
  assign link.dq      = dq_ff;
  assign cmd_ready_out = ready_ff;
  assign cmd_done_out  = done_ff;

  // ==========================================================
  // Frame sequencer; link clock is half the reference rate
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= flash_seq_pkg::H_IDLE;
      cs_n_ff  <= 1'b1;
      sclk_ff  <= 1'b0;
      dq_ff    <= 4'h0;
      sh_ff    <= 32'h0;
      left_ff  <= 6'h0;
      mode_ff  <= flash_seq_pkg::PROTO_EXT;
      gap_ff   <= 4'h0;
      ready_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        flash_seq_pkg::H_IDLE: begin
          ready_ff <= 1'b1;
          if (cmd_valid_in && ready_ff) begin
            ready_ff <= 1'b0;
            cs_n_ff  <= 1'b0;
            sh_ff    <= {cmd_opcode_in, cmd_addr_in};
            left_ff  <= cmd_has_addr_in ? flash_seq_pkg::ERASE_CMD_BITS
                                        : flash_seq_pkg::OPCODE_BITS;
            mode_ff  <= proto_mode_in;
            dq_ff    <= out_lanes({cmd_opcode_in, cmd_addr_in}, proto_mode_in);
            state_ff <= flash_seq_pkg::H_LOW;
          end
        end
        flash_seq_pkg::H_LOW: begin
          sclk_ff  <= 1'b1;
          left_ff  <= left_ff - {3'h0, flash_seq_pkg::lanes_of(mode_ff)};
          sh_ff    <= sh_ff << flash_seq_pkg::lanes_of(mode_ff);
          state_ff <= flash_seq_pkg::H_HIGH;
        end
        flash_seq_pkg::H_HIGH: begin
          sclk_ff <= 1'b0;
          if (left_ff == 6'h0) begin
            cs_n_ff  <= 1'b1;
            gap_ff   <= flash_seq_pkg::HOST_CS_HIGH_CYC;
            state_ff <= flash_seq_pkg::H_GAP;
          end else begin
            dq_ff    <= out_lanes(sh_ff, mode_ff);
            state_ff <= flash_seq_pkg::H_LOW;
          end
        end
        flash_seq_pkg::H_GAP: begin
          // Long chip-select high gap lets the device read the frame safely
          gap_ff <= gap_ff - 4'h1;
          if (gap_ff == 4'h1) begin
            done_ff  <= 1'b1;
            state_ff <= flash_seq_pkg::H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : flash_cmd_host
`default_nettype wire

// ==== flash_erase_device.sv ====
`default_nettype none
module flash_erase_device #(
  parameter int unsigned SMALL_CYC = flash_seq_pkg::SMALL_BLOCK_ERASE_CYC,
  parameter int unsigned BLOCK_CYC = flash_seq_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned FULL_CYC  = flash_seq_pkg::FULL_ARRAY_ERASE_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  spi_link_if.device       link,
  input  wire logic [1:0]  proto_mode_in,
  input  wire logic [63:0] sector_lock_in,
  input  wire logic        array_timeout_in,
  input  wire logic        flag_clear_in,
  output logic             wel_out,
  output logic             wip_out,
  output logic [7:0]       flag_status_out,
  output logic             erase_active_out,
  output logic [1:0]       erase_kind_out,
  output logic [23:0]      erase_addr_out
);
  // ==========================================================
  // Link clock domain: bit collection
  logic        armed_ff;
  logic [5:0]  bit_cnt_ff;
  logic [31:0] shift_ff;
  logic [1:0]  mode_s1_ff;
  logic [1:0]  mode_s2_ff;
  logic [2:0]  lanes;
  logic [31:0] nxt_shift;
  logic [6:0]  cnt_sum;

  assign lanes   = flash_seq_pkg::lanes_of(mode_s2_ff);
  assign cnt_sum = {1'b0, bit_cnt_ff} + {4'h0, lanes};

  always_comb begin
    unique case (lanes)
      3'h4:    nxt_shift = {shift_ff[27:0], link.dq};
      3'h2:    nxt_shift = {shift_ff[29:0], link.dq[1:0]};
      default: nxt_shift = {shift_ff[30:0], link.dq[0]};
    endcase
  end

  // Mode only settles after two link clock edges; change it between frames
  always_ff @(posedge link.sclk or posedge rst_in) begin
    if (rst_in) begin
      mode_s1_ff <= flash_seq_pkg::PROTO_EXT;
      mode_s2_ff <= flash_seq_pkg::PROTO_EXT;
    end else begin
      mode_s1_ff <= proto_mode_in;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  // Select high disarms, so the first edge of a frame restarts the count
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge link.sclk or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_ff <= 6'h0;
      shift_ff   <= 32'h0;
    end else begin
      shift_ff <= nxt_shift;
      if (!armed_ff) begin
        bit_cnt_ff <= {3'h0, lanes};
      end else if (cnt_sum > {1'b0, flash_seq_pkg::BIT_CNT_MAX}) begin
        bit_cnt_ff <= flash_seq_pkg::BIT_CNT_MAX;
      end else begin
        bit_cnt_ff <= cnt_sum[5:0];
      end
    end
  end

  // ==========================================================
  // Reference domain: frame end detection
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_s3_ff;
  logic frame_end;

  // Frame words are static while select is high, so sampling after sync is safe
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= link.cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end
  assign frame_end = cs_s2_ff && !cs_s3_ff;

  // ==========================================================
  // Command decode
  logic        len_op;
  logic        len_erase;
  logic [7:0]  op;
  logic [23:0] addr;
  logic        sect_locked;
  logic        any_locked;
  logic        is_wren;
  logic        is_wrdi;
  logic        is_part;
  logic        is_full;
  logic        is_susp;
  logic        is_res;

  assign len_op      = (bit_cnt_ff == flash_seq_pkg::OPCODE_BITS);
  assign len_erase   = (bit_cnt_ff == flash_seq_pkg::ERASE_CMD_BITS);
  assign op          = len_op ? shift_ff[7:0] : shift_ff[31:24];
  assign addr        = shift_ff[23:0];
  assign sect_locked = sector_lock_in[addr[flash_seq_pkg::SECTOR_MSB:flash_seq_pkg::SECTOR_LSB]];
  assign any_locked  = |sector_lock_in;
  assign is_wren = frame_end && len_op && (op == flash_seq_pkg::OP_WRITE_ENABLE);
  assign is_wrdi = frame_end && len_op && (op == flash_seq_pkg::OP_WRITE_DISABLE);
  assign is_part = frame_end && len_erase && ((op == flash_seq_pkg::OP_SMALL_ERASE) ||
                   (op == flash_seq_pkg::OP_BLOCK_ERASE));
  assign is_full = frame_end && len_op && (op == flash_seq_pkg::OP_FULL_ERASE);
  assign is_susp = frame_end && len_op && (op == flash_seq_pkg::OP_SUSPEND);
  assign is_res  = frame_end && len_op && (op == flash_seq_pkg::OP_RESUME);

  // ==========================================================
  // Erase engine
  flash_seq_pkg::erase_state_t state_ff;
  logic        wel_ff;
  logic        prot_err_ff;
  logic        erase_err_ff;
  logic [31:0] timer_ff;
  logic [1:0]  kind_ff;
  logic [23:0] addr_ff;
  logic        start_ok;
  logic        refuse;
  logic        finish;

  assign start_ok = (state_ff == flash_seq_pkg::ST_IDLE) && wel_ff &&
                    ((is_part && !sect_locked) || (is_full && !any_locked));
  assign refuse   = (state_ff == flash_seq_pkg::ST_IDLE) && wel_ff &&
                    ((is_part && sect_locked) || (is_full && any_locked));
  assign finish   = (state_ff == flash_seq_pkg::ST_ERASE) && (timer_ff == 32'h0);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= flash_seq_pkg::ST_IDLE;
      timer_ff <= 32'h0;
      kind_ff  <= flash_seq_pkg::KIND_NONE;
      addr_ff  <= 24'h0;
    end else begin
      unique case (state_ff)
        flash_seq_pkg::ST_IDLE: begin
          if (start_ok) begin
            state_ff <= flash_seq_pkg::ST_ERASE;
            addr_ff  <= addr;
            if (is_full) begin
              kind_ff  <= flash_seq_pkg::KIND_FULL;
              timer_ff <= FULL_CYC - 32'h1;
            end else if (op == flash_seq_pkg::OP_SMALL_ERASE) begin
              kind_ff  <= flash_seq_pkg::KIND_SMALL;
              timer_ff <= SMALL_CYC - 32'h1;
            end else begin
              kind_ff  <= flash_seq_pkg::KIND_BLOCK;
              timer_ff <= BLOCK_CYC - 32'h1;
            end
          end
        end
        flash_seq_pkg::ST_ERASE: begin
          if (finish) begin
            state_ff <= flash_seq_pkg::ST_IDLE;
            kind_ff  <= flash_seq_pkg::KIND_NONE;
          end else if (is_susp && (kind_ff != flash_seq_pkg::KIND_FULL)) begin
            state_ff <= flash_seq_pkg::ST_SUSP;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
        flash_seq_pkg::ST_SUSP: begin
          // Timer holds, so a resumed erase runs only its remaining time
          if (is_res) begin
            state_ff <= flash_seq_pkg::ST_ERASE;
          end
        end
        default: begin
          state_ff <= flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Latch: write commands are allowed while suspended, not while erasing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wel_ff <= 1'b0;
    end else if (start_ok) begin
      wel_ff <= 1'b0;
    end else if (finish && array_timeout_in) begin
      wel_ff <= 1'b0;
    end else if (state_ff != flash_seq_pkg::ST_ERASE) begin
      if (is_wren) begin
        wel_ff <= 1'b1;
      end else if (is_wrdi) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // Error flags: a new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prot_err_ff  <= 1'b0;
      erase_err_ff <= 1'b0;
    end else begin
      if (refuse) begin
        prot_err_ff <= 1'b1;
      end else if (flag_clear_in) begin
        prot_err_ff <= 1'b0;
      end
      if (refuse || (finish && array_timeout_in)) begin
        erase_err_ff <= 1'b1;
      end else if (flag_clear_in) begin
        erase_err_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wel_out          <= 1'b0;
      wip_out          <= 1'b0;
      flag_status_out  <= 8'h00;
      flag_status_out[flash_seq_pkg::FLAG_READY_BIT] <= 1'b1;
      erase_active_out <= 1'b0;
      erase_kind_out   <= flash_seq_pkg::KIND_NONE;
      erase_addr_out   <= 24'h0;
    end else begin
      wel_out          <= wel_ff;
      wip_out          <= (state_ff == flash_seq_pkg::ST_ERASE);
      flag_status_out  <= 8'h00;
      flag_status_out[flash_seq_pkg::FLAG_PROT_BIT]  <= prot_err_ff;
      flag_status_out[flash_seq_pkg::FLAG_ERASE_BIT] <= erase_err_ff;
      flag_status_out[flash_seq_pkg::FLAG_SUSP_BIT]  <= (state_ff == flash_seq_pkg::ST_SUSP);
      flag_status_out[flash_seq_pkg::FLAG_READY_BIT] <= (state_ff != flash_seq_pkg::ST_ERASE);
      erase_active_out <= (state_ff == flash_seq_pkg::ST_ERASE);
      erase_kind_out   <= kind_ff;
      erase_addr_out   <= addr_ff;
    end
  end
endmodule : flash_erase_device
`default_nettype wire

// ==== erase_link_checker.sv ====
`default_nettype none
// ==========================================================
// Link and device state checker
module erase_link_checker #(
  parameter int unsigned SMALL_CYC = 50,
  parameter int unsigned FULL_CYC  = 100
) (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       wel_out,
  input wire logic       wip_out,
  input wire logic [7:0] flag_status_out,
  input wire logic [1:0] erase_kind_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run_cnt_ff;
  logic [1:0]  last_kind_ff;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Busy run length, so durations are checked without long repetitions
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) run_cnt_ff <= 32'h0;
    else if (wip_out) run_cnt_ff <= run_cnt_ff + 32'h1;
    else run_cnt_ff <= 32'h0;
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) last_kind_ff <= 2'h0;
    else if (wip_out) last_kind_ff <= erase_kind_out;
  end

  // ==========================================================
  // Properties
  property p_idle_sclk; cs_n |-> !sclk; endproperty
  property p_cs_gap; $rose(cs_n) |-> cs_n [*5]; endproperty
  property p_wel_on_start; $rose(wip_out) |-> !wel_out; endproperty
  property p_kind_busy; wip_out |-> erase_kind_out != flash_seq_pkg::KIND_NONE; endproperty
  property p_start_on_cs; $rose(wip_out) |-> cs_n && $past(cs_n, 3); endproperty
  property p_wel_quiet; $changed(wel_out) |-> cs_n; endproperty
  property p_prot_flags;
    $rose(flag_status_out[flash_seq_pkg::FLAG_PROT_BIT]) |->
      flag_status_out[flash_seq_pkg::FLAG_ERASE_BIT] && wel_out && !wip_out;
  endproperty
  property p_small_dur;
    $fell(wip_out) && last_kind_ff == flash_seq_pkg::KIND_SMALL |-> run_cnt_ff == SMALL_CYC;
  endproperty
  property p_full_dur;
    $fell(wip_out) && last_kind_ff == flash_seq_pkg::KIND_FULL |-> run_cnt_ff == FULL_CYC;
  endproperty

  a_idle_sclk: assert property (p_idle_sclk) else $error("clock runs while deselected");
  a_cs_gap: assert property (p_cs_gap) else $error("select high too short");
  a_wel_on_start: assert property (p_wel_on_start) else $error("latch set in erase");
  a_kind_busy: assert property (p_kind_busy) else $error("busy with no erase kind");
  a_start_on_cs: assert property (p_start_on_cs) else $error("erase not after select");
  a_wel_quiet: assert property (p_wel_quiet) else $error("latch moved in frame");
  a_prot_flags: assert property (p_prot_flags) else $error("protection flags wrong");
  a_small_dur: assert property (p_small_dur) else $error("small erase length");
  a_full_dur: assert property (p_full_dur) else $error("full erase length");

  c_small: cover property ($rose(wip_out) && erase_kind_out == flash_seq_pkg::KIND_SMALL);
  c_full: cover property ($rose(wip_out) && erase_kind_out == flash_seq_pkg::KIND_FULL);
  c_susp: cover property ($rose(flag_status_out[flash_seq_pkg::FLAG_SUSP_BIT]));
  c_prot: cover property ($rose(flag_status_out[flash_seq_pkg::FLAG_PROT_BIT]));
endmodule : erase_link_checker
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
// ==========================================================
// Host and device joined over the link
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in, rst_in, cmd_valid_in, cmd_has_addr_in, array_timeout_in;
  logic        flag_clear_in, cmd_ready_out, cmd_done_out, wel_out, wip_out, wel2, wip2;
  logic [7:0]  cmd_opcode_in, flag_status_out, flags2;
  logic [23:0] cmd_addr_in, erase_addr_out;
  logic [1:0]  proto_mode_in, erase_kind_out;
  logic [63:0] sector_lock_in;
  logic        erase_active;
  int          errors, num_checks;
  spi_link_if  link();
  spi_link_if  raw_link();

  flash_cmd_host flash_cmd_host_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
    .cmd_valid_in(cmd_valid_in), .cmd_opcode_in(cmd_opcode_in), .cmd_addr_in(cmd_addr_in),
    .cmd_has_addr_in(cmd_has_addr_in), .proto_mode_in(proto_mode_in),
    .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out));
  flash_erase_device #(.SMALL_CYC(50), .BLOCK_CYC(80), .FULL_CYC(100)) flash_erase_device_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link), .proto_mode_in(proto_mode_in),
    .sector_lock_in(sector_lock_in), .array_timeout_in(array_timeout_in),
    .flag_clear_in(flag_clear_in), .wel_out(wel_out), .wip_out(wip_out),
    .flag_status_out(flag_status_out), .erase_active_out(erase_active),
    .erase_kind_out(erase_kind_out), .erase_addr_out(erase_addr_out));
  // Second device faces a bench driver that can send badly framed commands
  // Its erases never finish in this run, so the long default durations do no harm
  flash_erase_device flash_erase_device_inst_b (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(raw_link), .proto_mode_in(proto_mode_in),
    .sector_lock_in(sector_lock_in), .array_timeout_in(array_timeout_in),
    .flag_clear_in(flag_clear_in), .wel_out(wel2), .wip_out(wip2), .flag_status_out(flags2),
    .erase_active_out(), .erase_kind_out(), .erase_addr_out());
  erase_link_checker #(.SMALL_CYC(50), .FULL_CYC(100)) erase_link_checker_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cs_n(link.cs_n), .sclk(link.sclk),
    .wel_out(wel_out), .wip_out(wip_out), .flag_status_out(flag_status_out),
    .erase_kind_out(erase_kind_out));

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic has);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (cmd_ready_out !== 1'b1 && n < 200) begin
      @(negedge ref_clk_in);
      n++;
    end
    cmd_valid_in = 1'b1;
    cmd_opcode_in = op;
    cmd_addr_in = addr;
    cmd_has_addr_in = has;
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
    while (cmd_done_out !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 400) errors++;
    repeat (3) @(negedge ref_clk_in);
  endtask : send

  // Bits go out on lane zero, most significant first; the lane shows junk when released
  task automatic raw_frame(input int nbits, input logic [39:0] bits);
    raw_link.cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      raw_link.dq = {3'h0, bits[i]};
      #6;
      raw_link.sclk = 1'b1;
      #6;
      raw_link.sclk = 1'b0;
    end
    raw_link.cs_n = 1'b1;
    raw_link.dq = ~raw_link.dq;
    repeat (10) @(negedge ref_clk_in);
  endtask : raw_frame

  task automatic wait_idle();
    int n;
    n = 0;
    while (wip_out !== 1'b0 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 400) errors++;
  endtask : wait_idle

  // A throwaway frame lets the device pick up the new lane count
  task automatic set_mode(input logic [1:0] m);
    @(negedge ref_clk_in);
    proto_mode_in = m;
    send(flash_seq_pkg::OP_WRITE_DISABLE, 24'h0, 1'b0);
  endtask : set_mode

  task automatic clear_flags();
    @(negedge ref_clk_in);
    flag_clear_in = 1'b1;
    @(negedge ref_clk_in);
    flag_clear_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
  endtask : clear_flags

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    {rst_in, cmd_valid_in, cmd_has_addr_in, array_timeout_in, flag_clear_in} = 5'b10000;
    {cmd_opcode_in, cmd_addr_in, proto_mode_in, sector_lock_in} = '0;
    {raw_link.cs_n, raw_link.sclk, raw_link.dq} = 6'h20;
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    check({wel_out, wip_out, flag_status_out}, {2'b00, 8'h80});
    send(flash_seq_pkg::OP_SMALL_ERASE, 24'h001000, 1'b1);
    check({wip_out, flag_status_out}, {1'b0, 8'h80});
    send(flash_seq_pkg::OP_WRITE_ENABLE, 24'h0, 1'b0);
    check(wel_out, 1'b1);
    send(flash_seq_pkg::OP_SMALL_ERASE, 24'h012345, 1'b1);
    check({wip_out, wel_out, erase_kind_out}, {2'b10, flash_seq_pkg::KIND_SMALL});
    check(erase_active, 1'b1);
    check(erase_addr_out, 24'h012345);
    wait_idle();
    check({wip_out, flag_status_out}, {1'b0, 8'h80});
    for (int m = 0; m < 3; m++) begin
      set_mode(m[1:0]);
      send(flash_seq_pkg::OP_WRITE_ENABLE, 24'h0, 1'b0);
      check(wel_out, 1'b1);
      send(flash_seq_pkg::OP_WRITE_DISABLE, 24'h0, 1'b0);
      check(wel_out, 1'b0);
    end
    send(flash_seq_pkg::OP_WRITE_ENABLE, 24'h0, 1'b0);
    send(flash_seq_pkg::OP_BLOCK_ERASE, 24'h05a5a5, 1'b1);
    check({wip_out, erase_kind_out}, {1'b1, flash_seq_pkg::KIND_BLOCK});
    send(flash_seq_pkg::OP_SUSPEND, 24'h0, 1'b0);
    check({wip_out, flag_status_out[6]}, 2'b01);
    check(erase_active, 1'b0);
    send(flash_seq_pkg::OP_RESUME, 24'h0, 1'b0);
    check({wip_out, flag_status_out[6]}, 2'b10);
    wait_idle();
    check(erase_addr_out, 24'h05a5a5);
    set_mode(flash_seq_pkg::PROTO_EXT);
    sector_lock_in = 64'h8;
    send(flash_seq_pkg::OP_WRITE_ENABLE, 24'h0, 1'b0);
    send(flash_seq_pkg::OP_BLOCK_ERASE, 24'h03ffff, 1'b1);
    check({wip_out, wel_out, flag_status_out}, {2'b01, 8'ha2});
    clear_flags();
    check(flag_status_out, 8'h80);
    send(flash_seq_pkg::OP_FULL_ERASE, 24'h0, 1'b0);
    check({wip_out, wel_out, flag_status_out}, {2'b01, 8'ha2});
    sector_lock_in = 64'h0;
    clear_flags();
    array_timeout_in = 1'b1;
    send(flash_seq_pkg::OP_FULL_ERASE, 24'h0, 1'b0);
    check({wip_out, erase_kind_out}, {1'b1, flash_seq_pkg::KIND_FULL});
    wait_idle();
    repeat (2) @(negedge ref_clk_in);
    check({wel_out, flag_status_out}, {1'b0, 8'ha0});
    array_timeout_in = 1'b0;
    raw_frame(9, 40'h00c);
    check(wel2, 1'b0);
    raw_frame(8, 40'h06);
    check(wel2, 1'b1);
    raw_frame(33, {7'h0, flash_seq_pkg::OP_SMALL_ERASE, 24'h001000, 1'b0});
    check({wip2, wel2, flags2}, {2'b01, 8'h80});
    raw_frame(32, {8'h0, flash_seq_pkg::OP_SMALL_ERASE, 24'h001000});
    check({wip2, wel2}, 2'b10);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
